//--- hdl/dps_mul.sv
// multiplier array: four halfword lanes and two word lanes, purely combinational
module dps_mul import dps_pkg::*; (
	// operands in, products out
	dps_mul_if.mul m
);
	genvar i;
	// halfword lanes give both the plain integer and the doubled fractional product
	generate
		for (i = 0; i < 4; i++) begin : g_half
			logic signed [31:0] raw;
			logic corner;
			assign raw = $signed(m.src_a[16*i +: 16]) * $signed(m.src_b[16*i +: 16]);
			assign corner = (m.src_a[16*i +: 16] == MIN_Q15) && (m.src_b[16*i +: 16] == MIN_Q15);
			assign m.prod_int[i] = raw;
			assign m.prod_q15[i] = corner ? MAX_Q31 : {raw[30:0], 1'b0};
			assign m.sat_q15[i] = corner;
		end
	endgenerate
	// word lanes; doubling minus one squared would wrap, so the corner is replaced
	generate
		for (i = 0; i < 2; i++) begin : g_word
			logic signed [63:0] raw;
			logic corner;
			assign raw = $signed(m.src_a[32*i +: 32]) * $signed(m.src_b[32*i +: 32]);
			assign corner = (m.src_a[32*i +: 32] == MIN_Q31) && (m.src_b[32*i +: 32] == MIN_Q31);
			assign m.prod_q31[i] = corner ? MAX_Q63 : {raw[62:0], 1'b0};
			assign m.sat_q31[i] = corner;
		end
	endgenerate
endmodule // dps_mul

//--- hdl/dps_mul_if.sv
// interface carrying operands and products between the unit and its multiplier array
interface dps_mul_if;
	logic [63:0] src_a;
	logic [63:0] src_b;
	logic [3:0][31:0] prod_int;
	logic [3:0][31:0] prod_q15;
	logic [3:0] sat_q15;
	logic [1:0][63:0] prod_q31;
	logic [1:0] sat_q31;
	modport host (output src_a, output src_b, input prod_int, input prod_q15, input sat_q15,
		input prod_q31, input sat_q31);
	modport mul (input src_a, input src_b, output prod_int, output prod_q15, output sat_q15,
		output prod_q31, output sat_q31);
endinterface : dps_mul_if

//--- hdl/dps_pkg.sv
// package of constants and types for the dot product subtract unit
// Function
// - quad halfword integer dot product subtracts from 128-bit accumulator
// - products sign-extended, 34-bit sum, sign-extended subtract
// - integer forms never saturate nor touch flags
// - pair halfword integer subtracts from 64-bit accumulator
// - 64-bit forms use low words, write sign-extended halves
// - two-bit selector picks accumulator zero to three
// - Q15 products doubled into Q31
// - minus one squared gives Q31 maximum, sets flag
// - flags bits 16 to 19, one per accumulator
// - pair fractional sums into 64 bits, no accumulator clamp
// - quad fractional sum sign-extended to 128, no clamp
// - word pair doubled to Q63, corner gives Q63 maximum
// - word pair result clamped to Q63 range
// - word pair accumulator clamp sets selected flag
// - operand values never raise an exception
// - opcode, function, sub-operation, selector and zero fields
// - pair integer form is sub-op 00001, function 110000
// - pair fractional form is sub-op 00101, function 110000
// - quad fractional form is sub-op 00101, function 110100
// - word pair form is sub-op 01101, function 110100
package dps_pkg;
	// instruction fields
	localparam logic [5:0] EXT_MAJOR_OPCODE = 6'h1F;
	localparam logic [5:0] DOT_GROUP_FUNCTION_32 = 6'h30;
	localparam logic [5:0] DOT_GROUP_FUNCTION_64 = 6'h34;
	localparam logic [4:0] SUB_INT_HALF = 5'h01;
	localparam logic [4:0] SUB_FRAC_HALF = 5'h05;
	localparam logic [4:0] SUB_FRAC_WORD_SAT = 5'h0D;
	localparam int MAJOR_LSB = 26;
	localparam int ZERO_LSB = 13;
	localparam int SEL_LSB = 11;
	localparam int SUBOP_LSB = 6;
	// fixed point corners
	localparam logic [15:0] MIN_Q15 = 16'h8000;
	localparam logic [31:0] MIN_Q31 = 32'h80000000;
	localparam logic [31:0] MAX_Q31 = 32'h7FFFFFFF;
	localparam logic [63:0] MAX_Q63 = 64'h7FFFFFFFFFFFFFFF;
	localparam logic [63:0] MIN_Q63 = 64'h8000000000000000;
	// control register flag field
	localparam int FLAG_LSB = 16;
	localparam int NUM_ACC = 4;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [63:0] ACC_RESET = 64'h0000000000000000;
	// bus register map
	localparam logic [7:0] ACC_REGION_END = 8'h40;
	localparam logic [1:0] WORD_HI_LOW = 2'h0;
	localparam logic [1:0] WORD_HI_HIGH = 2'h1;
	localparam logic [1:0] WORD_LO_LOW = 2'h2;
	localparam logic [1:0] WORD_LO_HIGH = 2'h3;
	localparam logic [7:0] CTRL_OFFSET = 8'h40;
	// decoded operations
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_INT_QUAD = 3'b001,
		OP_INT_PAIR = 3'b010,
		OP_FRAC_PAIR = 3'b011,
		OP_FRAC_QUAD = 3'b100,
		OP_FRAC_WORD = 3'b101
	} dps_op_t;
endpackage : dps_pkg

//--- hdl/dps_unit.sv
// dot product subtract unit: decode, accumulators, flags and ahb-lite register access
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
module dps_unit import dps_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// instruction issue from decode
	input wire logic issue_valid,
	input wire logic [31:0] issue_word,
	input wire logic [63:0] first_source_reg,
	input wire logic [63:0] second_source_reg,
	input wire logic dsp_enabled,
	// completion and status
	output logic issue_done,
	output logic reserved_instr,
	output logic dsp_disabled,
	output logic [31:0] dsp_control_register
);
	// decode of one instruction word; anything else is a reserved instruction
	function automatic dps_op_t decode_op(input logic [31:0] w);
		dps_op_t op;
		logic [4:0] sub;
		op = OP_NONE;
		sub = w[SUBOP_LSB +: 5];
		if (w[31:MAJOR_LSB] == EXT_MAJOR_OPCODE && w[15:ZERO_LSB] == 3'h0) begin
			if (w[5:0] == DOT_GROUP_FUNCTION_32) begin
				if (sub == SUB_INT_HALF) begin
					op = OP_INT_PAIR;
				end else if (sub == SUB_FRAC_HALF) begin
					op = OP_FRAC_PAIR;
				end
			end else if (w[5:0] == DOT_GROUP_FUNCTION_64) begin
				if (sub == SUB_INT_HALF) begin
					op = OP_INT_QUAD;
				end else if (sub == SUB_FRAC_HALF) begin
					op = OP_FRAC_QUAD;
				end else if (sub == SUB_FRAC_WORD_SAT) begin
					op = OP_FRAC_WORD;
				end
			end
		end
		return op;
	endfunction

	// true when a byte address falls in the accumulator window
	function automatic logic is_acc_addr(input logic [7:0] a);
		return a < ACC_REGION_END;
	endfunction

	// state
	logic [63:0] acc_hi_r [NUM_ACC];
	logic [63:0] acc_hi_nxt [NUM_ACC];
	logic [63:0] acc_lo_r [NUM_ACC];
	logic [63:0] acc_lo_nxt [NUM_ACC];
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic done_r;
	logic done_nxt;
	logic rsv_r;
	logic rsv_nxt;
	logic dis_r;
	logic dis_nxt;
	logic dp_valid_r;
	logic dp_valid_nxt;
	logic dp_write_r;
	logic dp_write_nxt;
	logic [7:0] dp_addr_r;
	logic [7:0] dp_addr_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// datapath wires
	dps_op_t op;
	logic [1:0] sel;
	logic go;
	logic [127:0] acc128;
	logic [63:0] acc64;
	logic [33:0] sum_iq;
	logic [32:0] sum_ip;
	logic [63:0] sum_fq;
	logic [63:0] sum_fp;
	logic [127:0] sum_fw;
	logic [128:0] diff_fw;
	logic [63:0] diff64;
	logic [127:0] res128;
	logic sat_acc;
	logic set_flag;
	logic bus_wr;
	logic addr_phase;

	dps_mul_if mi ();

	// multiplier array sees the two source registers directly
	assign mi.src_a = first_source_reg;
	assign mi.src_b = second_source_reg;

	dps_mul u_mul (
		.m(mi.mul)
	);

	// issue decode; the selector addresses one of four pairs, pair zero is the original one
	assign op = decode_op(issue_word);
	assign sel = issue_word[SEL_LSB +: 2];
	assign go = issue_valid && dsp_enabled && (op != OP_NONE);
	assign acc128 = {acc_hi_r[sel], acc_lo_r[sel]};
	assign acc64 = {acc_hi_r[sel][31:0], acc_lo_r[sel][31:0]};

	// dot product sums, each term sign-extended before the add
	assign sum_iq = {{2{mi.prod_int[3][31]}}, mi.prod_int[3]} + {{2{mi.prod_int[2][31]}}, mi.prod_int[2]}
		+ {{2{mi.prod_int[1][31]}}, mi.prod_int[1]} + {{2{mi.prod_int[0][31]}}, mi.prod_int[0]};
	assign sum_ip = {mi.prod_int[1][31], mi.prod_int[1]} + {mi.prod_int[0][31], mi.prod_int[0]};
	assign sum_fp = {{32{mi.prod_q15[1][31]}}, mi.prod_q15[1]} + {{32{mi.prod_q15[0][31]}}, mi.prod_q15[0]};
	assign sum_fq = sum_fp + {{32{mi.prod_q15[3][31]}}, mi.prod_q15[3]}
		+ {{32{mi.prod_q15[2][31]}}, mi.prod_q15[2]};
	assign sum_fw = {{64{mi.prod_q31[1][63]}}, mi.prod_q31[1]} + {{64{mi.prod_q31[0][63]}}, mi.prod_q31[0]};
	assign diff_fw = {acc_hi_r[sel][63], acc128} - {sum_fw[127], sum_fw};
	assign sat_acc = diff_fw[64] != diff_fw[63];

	// result of the selected form; the integer forms never compute a flag
	always_comb begin
		diff64 = 64'h0000000000000000;
		res128 = acc128;
		set_flag = 1'b0;
		case (op)
			OP_INT_QUAD: begin
				res128 = acc128 - {{94{sum_iq[33]}}, sum_iq};
			end
			OP_INT_PAIR: begin
				diff64 = acc64 - {{31{sum_ip[32]}}, sum_ip};
				res128 = {{32{diff64[63]}}, diff64[63:32], {32{diff64[31]}}, diff64[31:0]};
			end
			OP_FRAC_PAIR: begin
				diff64 = acc64 - sum_fp;
				res128 = {{32{diff64[63]}}, diff64[63:32], {32{diff64[31]}}, diff64[31:0]};
				set_flag = |mi.sat_q15[1:0];
			end
			OP_FRAC_QUAD: begin
				res128 = acc128 - {{64{sum_fq[63]}}, sum_fq};
				set_flag = |mi.sat_q15;
			end
			OP_FRAC_WORD: begin
				if (sat_acc) begin
					// only bits 64 and 63 are compared, so the clamp is to the q63 range
					res128 = diff_fw[64] ? {{64{1'b1}}, MIN_Q63} : {64'h0000000000000000, MAX_Q63};
				end else begin
					res128 = diff_fw[127:0];
				end
				set_flag = sat_acc || (|mi.sat_q31);
			end
			default: begin
				res128 = acc128;
			end
		endcase
	end

	// bus phases: hreadyout is always high, so every address phase is taken
	assign addr_phase = hsel && htrans[1] && hready;
	assign bus_wr = dp_valid_r && dp_write_r;

	// accumulators and flags; an instruction wins over a bus write in the same cycle
	always_comb begin
		for (int k = 0; k < NUM_ACC; k++) begin
			acc_hi_nxt[k] = acc_hi_r[k];
			acc_lo_nxt[k] = acc_lo_r[k];
			if (bus_wr && is_acc_addr(dp_addr_r) && dp_addr_r[5:4] == 2'(k)) begin
				case (dp_addr_r[3:2])
					WORD_HI_LOW: acc_hi_nxt[k][31:0] = hwdata;
					WORD_HI_HIGH: acc_hi_nxt[k][63:32] = hwdata;
					WORD_LO_LOW: acc_lo_nxt[k][31:0] = hwdata;
					WORD_LO_HIGH: acc_lo_nxt[k][63:32] = hwdata;
					default: acc_lo_nxt[k] = acc_lo_r[k];
				endcase
			end
		end
		flags_nxt = flags_r;
		if (bus_wr && dp_addr_r == CTRL_OFFSET) begin
			flags_nxt = hwdata[FLAG_LSB +: NUM_ACC];
		end
		if (go) begin
			acc_hi_nxt[sel] = res128[127:64];
			acc_lo_nxt[sel] = res128[63:0];
			if (set_flag) begin
				flags_nxt[sel] = 1'b1;
			end
		end
	end

	// one-cycle completion pulses; operand values alone never raise an exception
	always_comb begin
		done_nxt = go;
		rsv_nxt = issue_valid && (op == OP_NONE);
		dis_nxt = issue_valid && !dsp_enabled && (op != OP_NONE);
	end

	// bus next state: read data is captured during the address phase
	always_comb begin
		dp_valid_nxt = addr_phase;
		dp_write_nxt = hwrite;
		dp_addr_nxt = haddr[7:0];
		rdata_nxt = rdata_r;
		if (addr_phase && !hwrite) begin
			rdata_nxt = 32'h00000000;
			if (haddr[31:8] == 24'h000000 && is_acc_addr(haddr[7:0])) begin
				case (haddr[3:2])
					WORD_HI_LOW: rdata_nxt = acc_hi_r[haddr[5:4]][31:0];
					WORD_HI_HIGH: rdata_nxt = acc_hi_r[haddr[5:4]][63:32];
					WORD_LO_LOW: rdata_nxt = acc_lo_r[haddr[5:4]][31:0];
					WORD_LO_HIGH: rdata_nxt = acc_lo_r[haddr[5:4]][63:32];
					default: rdata_nxt = 32'h00000000;
				endcase
			end else if (haddr[31:0] == {24'h000000, CTRL_OFFSET}) begin
				rdata_nxt = dsp_control_register;
			end
		end
		if (addr_phase && hwrite && haddr[31:8] != 24'h000000) begin
			dp_addr_nxt = 8'hFF; // unmapped upper space, write is dropped
		end
	end

	// registers of all groups
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < NUM_ACC; k++) begin
				acc_hi_r[k] <= ACC_RESET;
				acc_lo_r[k] <= ACC_RESET;
			end
			flags_r <= FLAGS_RESET;
			done_r <= 1'b0;
			rsv_r <= 1'b0;
			dis_r <= 1'b0;
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= 8'h00;
			rdata_r <= 32'h00000000;
		end else begin
			for (int k = 0; k < NUM_ACC; k++) begin
				acc_hi_r[k] <= acc_hi_nxt[k];
				acc_lo_r[k] <= acc_lo_nxt[k];
			end
			flags_r <= flags_nxt;
			done_r <= done_nxt;
			rsv_r <= rsv_nxt;
			dis_r <= dis_nxt;
			dp_valid_r <= dp_valid_nxt;
			dp_write_r <= dp_write_nxt;
			dp_addr_r <= dp_addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;
	assign issue_done = done_r;
	assign reserved_instr = rsv_r;
	assign dsp_disabled = dis_r;
	assign dsp_control_register = {12'h000, flags_r, 16'h0000};

	// helper for the checks: selector of the previous cycle
	logic [1:0] last_sel_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_sel_r <= 2'h0;
		end else begin
			last_sel_r <= sel;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_int_flags_kept;
		go && (op == OP_INT_QUAD || op == OP_INT_PAIR) && !bus_wr |=> flags_r == $past(flags_r);
	endproperty
	a_int_flags_kept: assert property (p_int_flags_kept) else $error("integer form changed a flag");

	property p_q15_corner_flag;
		go && op == OP_FRAC_PAIR && first_source_reg[15:0] == MIN_Q15 && second_source_reg[15:0] == MIN_Q15
			|=> flags_r[last_sel_r] && dsp_control_register[FLAG_LSB + 32'(last_sel_r)];
	endproperty
	a_q15_corner_flag: assert property (p_q15_corner_flag) else $error("q15 corner did not set flag");

	property p_pair_sext;
		go && (op == OP_INT_PAIR || op == OP_FRAC_PAIR) && !bus_wr
			|=> acc_hi_r[last_sel_r][63:32] == {32{acc_hi_r[last_sel_r][31]}}
			&& acc_lo_r[last_sel_r][63:32] == {32{acc_lo_r[last_sel_r][31]}};
	endproperty
	a_pair_sext: assert property (p_pair_sext) else $error("64-bit form not sign-extended");

	property p_word_clamped;
		go && op == OP_FRAC_WORD && !bus_wr |=> acc_hi_r[last_sel_r] == {64{acc_lo_r[last_sel_r][63]}};
	endproperty
	a_word_clamped: assert property (p_word_clamped) else $error("word pair result outside q63");

	property p_word_sat_flag;
		go && op == OP_FRAC_WORD && sat_acc |=> flags_r[last_sel_r] && issue_done;
	endproperty
	a_word_sat_flag: assert property (p_word_sat_flag) else $error("clamp did not set flag");

	property p_done_pulse;
		go |=> issue_done && !reserved_instr && !dsp_disabled;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("accepted op gave no completion");

	property p_no_data_exception;
		issue_valid && dsp_enabled && op != OP_NONE |=> !reserved_instr && !dsp_disabled;
	endproperty
	a_no_data_exception: assert property (p_no_data_exception) else $error("exception on valid op");

	property p_iq_zero_kept;
		go && op == OP_INT_QUAD && first_source_reg == 64'h0000000000000000 && !bus_wr
			|=> {acc_hi_r[last_sel_r], acc_lo_r[last_sel_r]} == $past({acc_hi_r[sel], acc_lo_r[sel]});
	endproperty
	a_iq_zero_kept: assert property (p_iq_zero_kept) else $error("zero dot product moved accumulator");

	property p_other_acc_kept;
		go && sel == 2'h0 && !bus_wr |=> acc_hi_r[1] == $past(acc_hi_r[1]) && acc_lo_r[3] == $past(acc_lo_r[3]);
	endproperty
	a_other_acc_kept: assert property (p_other_acc_kept) else $error("unselected accumulator changed");

	property p_q15_double;
		!mi.sat_q15[0] |-> mi.prod_q15[0] == 32'($signed(first_source_reg[15:0]) * $signed(second_source_reg[15:0]) * 2);
	endproperty
	a_q15_double: assert property (p_q15_double) else $error("q15 product not doubled");

	c_word_sat: cover property (go && op == OP_FRAC_WORD && sat_acc);
	c_q15_corner: cover property (go && op == OP_FRAC_QUAD && |mi.sat_q15);
	c_int_quad: cover property (go && op == OP_INT_QUAD ##1 go && op == OP_INT_PAIR);
	c_bus_read: cover property (addr_phase && !hwrite ##1 hrdata != 32'h00000000);
endmodule // dps_unit

//--- testbench/dps_core_model.sv
// processor-side model: offers instructions and operands on the issue port
module dps_core_model (
	// clock
	input wire logic hclk,
	// issue port
	output logic issue_valid,
	output logic [31:0] issue_word,
	output logic [63:0] first_source_reg,
	output logic [63:0] second_source_reg,
	output logic dsp_enabled,
	// answers
	input wire logic issue_done,
	input wire logic reserved_instr,
	input wire logic dsp_disabled
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle issue port at time zero
	initial begin
		issue_valid = 1'b0;
		issue_word = 32'h0;
		first_source_reg = 64'h0;
		second_source_reg = 64'h0;
		dsp_enabled = 1'b1;
	end
	// one edge of request, then operand lines inverted so a stale value can never pass
	task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b, input logic en,
		output logic [2:0] resp);
		@(posedge hclk);
		issue_valid <= 1'b1;
		issue_word <= w;
		first_source_reg <= a;
		second_source_reg <= b;
		dsp_enabled <= en;
		@(posedge hclk);
		issue_valid <= 1'b0;
		issue_word <= ~w;
		first_source_reg <= ~a;
		second_source_reg <= ~b;
		#1;
		resp = {issue_done, reserved_instr, dsp_disabled};
	endtask
endmodule // dps_core_model

//--- testbench/tb_dps_unit.sv
// self-checking bench for the dot product subtract unit
module tb_dps_unit import dps_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, issue_word, ctrl;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [63:0] rs_v, rt_v;
	logic issue_valid, dsp_enabled, issue_done, reserved_instr, dsp_disabled;
	int err_count, checks, cycles;
	assign hready = hreadyout;
	// clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// cycle ceiling: the whole run needs well under a thousand cycles
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end
	dps_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid), .issue_word(issue_word),
		.first_source_reg(rs_v), .second_source_reg(rt_v), .dsp_enabled(dsp_enabled),
		.issue_done(issue_done), .reserved_instr(reserved_instr), .dsp_disabled(dsp_disabled),
		.dsp_control_register(ctrl));
	dps_core_model u_core (.hclk(hclk), .issue_valid(issue_valid), .issue_word(issue_word),
		.first_source_reg(rs_v), .second_source_reg(rt_v), .dsp_enabled(dsp_enabled),
		.issue_done(issue_done), .reserved_instr(reserved_instr), .dsp_disabled(dsp_disabled));
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// single word transfer; read data is taken at the edge that ends the data phase
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// word i of an accumulator pair: hi low, hi high, lo low, lo high
	task automatic set_acc(input logic [1:0] s, input logic [127:0] v);
		logic [31:0] q;
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, {26'h0, s, 4'h0} + 32'(4 * i), v[32 * (i ^ 2) +: 32], q);
		end
	endtask
	task automatic get_acc(input logic [1:0] s, output logic [127:0] v);
		logic [31:0] q;
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, {26'h0, s, 4'h0} + 32'(4 * i), 32'h0, q);
			v[32 * (i ^ 2) +: 32] = q;
		end
	endtask
	// reference result {flag, new accumulator pair}
	function automatic logic [128:0] ref_op(input dps_op_t k, input logic [127:0] acc, input logic [63:0] a,
		input logic [63:0] b);
		logic signed [127:0] s;
		logic signed [63:0] w;
		logic signed [31:0] p;
		logic [128:0] x;
		logic f;
		s = '0;
		f = 1'b0;
		if (k == OP_FRAC_WORD) begin
			for (int i = 0; i < 2; i++) begin
				w = ($signed(a[32 * i +: 32]) * $signed(b[32 * i +: 32])) <<< 1;
				if (a[32 * i +: 32] == MIN_Q31 && b[32 * i +: 32] == MIN_Q31) begin
					w = MAX_Q63;
					f = 1'b1;
				end
				s = s + w;
			end
			x = {acc[127], acc} - {s[127], s};
			if (x[64] != x[63]) begin
				x = x[64] ? {65'h1FFFFFFFFFFFFFFFF, MIN_Q63} : {65'h0, MAX_Q63};
				f = 1'b1;
			end
			return {f, x[127:0]};
		end
		for (int i = 0; i < ((k == OP_INT_PAIR || k == OP_FRAC_PAIR) ? 2 : 4); i++) begin
			p = $signed(a[16 * i +: 16]) * $signed(b[16 * i +: 16]);
			if (k == OP_FRAC_PAIR || k == OP_FRAC_QUAD) begin
				w[0] = a[16 * i +: 16] == MIN_Q15 && b[16 * i +: 16] == MIN_Q15;
				p = w[0] ? MAX_Q31 : p <<< 1;
				f = f | w[0];
			end
			s = s + p;
		end
		if (k == OP_INT_QUAD || k == OP_FRAC_QUAD) begin
			return {f, acc - s};
		end
		x[63:0] = {acc[95:64], acc[31:0]} - s[63:0];
		return {f, {32{x[63]}}, x[63:32], {32{x[31]}}, x[31:0]};
	endfunction
	function automatic logic [31:0] word_for(input dps_op_t k, input logic [1:0] s);
		logic [5:0] fn;
		logic [4:0] so;
		fn = (k == OP_INT_PAIR || k == OP_FRAC_PAIR) ? DOT_GROUP_FUNCTION_32 : DOT_GROUP_FUNCTION_64;
		so = (k == OP_FRAC_WORD) ? SUB_FRAC_WORD_SAT : (k == OP_INT_QUAD || k == OP_INT_PAIR) ? SUB_INT_HALF : SUB_FRAC_HALF;
		return {EXT_MAJOR_OPCODE, 10'h0, 3'h0, s, so, fn};
	endfunction
	// preload accumulator and flags, execute one instruction, compare all it may touch
	task automatic run_op(input dps_op_t k, input logic [1:0] s, input logic [127:0] acc, input logic [63:0] a,
		input logic [63:0] b, input logic [3:0] fl);
		logic [2:0] resp;
		logic [128:0] e;
		logic [127:0] v;
		logic [31:0] q;
		e = ref_op(k, acc, a, b);
		set_acc(s, acc);
		ahb(1'b1, {24'h0, CTRL_OFFSET}, {12'h0, fl, 16'h0}, q);
		u_core.issue(word_for(k, s), a, b, 1'b1, resp);
		check(resp, 3'b100);
		get_acc(s, v);
		check(v, e[127:0]);
		check(ctrl, {12'h0, fl | ({3'h0, e[128]} << s), 16'h0});
	endtask
	// state after reset; the unmapped region reads zero and ignores writes
	task automatic t_reset();
		logic [127:0] v;
		logic [31:0] q;
		get_acc(2'h0, v);
		check(v, {2{ACC_RESET}});
		ahb(1'b0, {24'h0, CTRL_OFFSET}, 32'h0, q);
		check(q, {12'h0, FLAGS_RESET, 16'h0});
		ahb(1'b1, 32'h80, 32'hFFFFFFFF, q);
		ahb(1'b0, 32'h80, 32'h0, q);
		check(q, 32'h0);
		check({hreadyout, hresp}, 2'b10);
	endtask
	// integer forms: corner operands never saturate and preset flags survive
	task automatic t_int();
		run_op(OP_INT_QUAD, 2'h2, 128'h10000000000000000, 64'h80007FFF80000003, 64'h80008000FFFFFFFB, 4'hA);
		run_op(OP_INT_PAIR, 2'h1, 128'h5A5A5A5A000000001234567880000000, 64'hFFFFFFFF80008000, 64'h1234567880007FFF,
			4'h5);
		run_op(OP_INT_QUAD, 2'h1, 128'hFEDCBA9876543210, 64'h0, 64'h7FFF8000FFFF0001, 4'h3);
	endtask
	// pair fraction with one corner lane, every accumulator in turn
	task automatic t_frac_pair();
		for (int s = 0; s < 4; s++) begin
			run_op(OP_FRAC_PAIR, 2'(s), 128'h0, 64'h80004000, 64'h8000C000, 4'h0);
		end
		// corner in the low lane, unused upper words and a preset flag
		run_op(OP_FRAC_PAIR, 2'h2, 128'h000000007FFFFFFF0000000100000000, 64'h7FFF8000, 64'h00028000, 4'h8);
	endtask
	task automatic t_frac_quad();
		run_op(OP_FRAC_QUAD, 2'h3, 128'hFFFFFFFFFFFFFFFF8000000000000000, 64'h800080007FFF0001, 64'h800080007FFFFFFF,
			4'h0);
	endtask
	// word pair: underflow clamp, overflow clamp, product corner without clamp
	task automatic t_word();
		run_op(OP_FRAC_WORD, 2'h0, 128'hFFFFFFFFFFFFFFFF8000000000000001, 64'h140000000, 64'h140000000, 4'h0);
		run_op(OP_FRAC_WORD, 2'h3, 128'h7FFFFFFFFFFFFFF0, 64'h100000001, 64'h1FFFFFFF0, 4'h0);
		run_op(OP_FRAC_WORD, 2'h2, 128'h0, 64'h8000000080000000, 64'h8000000040000000, 4'h1);
	endtask
	// undecodable words and a disabled unit leave accumulator and flags alone
	task automatic t_refuse();
		logic [2:0] resp;
		logic [127:0] v;
		logic [31:0] w;
		w = word_for(OP_FRAC_PAIR, 2'h1);
		set_acc(2'h1, 128'h0123456789ABCDEF);
		ahb(1'b1, {24'h0, CTRL_OFFSET}, 32'h0, v[31:0]);
		u_core.issue(w | 32'h00002000, 64'h8000, 64'h8000, 1'b1, resp);
		check(resp, 3'b010);
		u_core.issue(w ^ 32'h04000000, 64'h8000, 64'h8000, 1'b1, resp);
		check(resp, 3'b010);
		u_core.issue(w, 64'h8000, 64'h8000, 1'b0, resp);
		check(resp, 3'b001);
		get_acc(2'h1, v);
		check(v, 128'h0123456789ABCDEF);
		check(ctrl, 32'h0);
	endtask
	// reset, then the scenarios in order
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_int();
		t_frac_pair();
		t_frac_quad();
		t_word();
		t_refuse();
		results();
	end
endmodule // tb_dps_unit
